/* src/basic_mode_control.sv */
// basic mode control register with strap loading, soft reset and mode outputs
`timescale 1ns/10ps
module basic_mode_control
    import bmc_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // register access
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    output logic      [15:0] REG_RDATA,
    // straps: pins and software strap bits
    input  wire logic [2:0]  PIN_STRAP,
    input  wire logic        SOFT_STRAP_MODE,
    input  wire logic        CONFIG_DONE,
    // power-down pin, active low
    input  wire logic        INTERRUPT_POWERDOWN_PIN_N,
    // negotiation engine
    input  wire logic        AN_STARTED,
    // MII side
    input  wire logic        TX_EN,
    // outputs
    output phy_ctrl_s        CTRL,
    output logic             PHY_SOFT_RESET,
    output logic             COL
);
    typedef struct packed {
        logic [2:0]  pin_meta;
        logic [2:0]  pin_sync;
        logic [1:0]  pd_sync;
        logic        tx_meta;
        logic        tx_sync;
        logic        strap_load;
        logic [1:0]  strap_wait;
        strap_s      sw_strap;
        logic        sw_valid;
        logic [15:0] bmc;
        logic [7:0]  sr_cnt;
        phy_ctrl_s   ctrl;
        logic        sreset;
        logic [15:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;
    strap_s dflt;
    logic   col_int;
    logic   wr_hit;

    assign wr_hit = REG_WR && (REG_ADDR == BASIC_MODE_CONTROL_ADDR);

    // software strap wins over the pin strap
    always_comb begin
        dflt = st.sw_valid ? st.sw_strap : strap_s'(st.pin_sync);
    end

    // register next state
    always_comb begin
        next_st = st;
        next_st.pin_meta = PIN_STRAP;
        next_st.pin_sync = st.pin_meta;
        next_st.pd_sync  = {st.pd_sync[0], INTERRUPT_POWERDOWN_PIN_N};
        next_st.tx_meta  = TX_EN;
        next_st.tx_sync  = st.tx_meta;
        // hold the strap load until the pin synchroniser has filled
        next_st.strap_wait = {st.strap_wait[0], 1'b0};
        next_st.strap_load = st.strap_wait[1];
        // software strap bits written only in strap mode
        if (wr_hit && SOFT_STRAP_MODE) begin
            next_st.sw_strap = {REG_WDATA[AUTONEG_BIT], REG_WDATA[SPEED_BIT],
                                REG_WDATA[DUPLEX_BIT]};
        end
        if (SOFT_STRAP_MODE && CONFIG_DONE) begin
            next_st.sw_valid = 1'b1;
            next_st.strap_load = 1'b1;
        end
        // settled pin straps after release, or config done, load strap defaults
        if (st.strap_load) begin
            next_st.bmc[AUTONEG_BIT] = dflt.autoneg;
            next_st.bmc[SPEED_BIT]   = dflt.speed;
            next_st.bmc[DUPLEX_BIT]  = dflt.duplex;
        end
        if (st.sr_cnt != 8'h00) begin
            // soft reset running: hold defaults, bit 15 reads one
            next_st.sr_cnt = st.sr_cnt - 8'h01;
            next_st.bmc = '0;
            next_st.bmc[RESET_BIT] = 1'b1;
            next_st.bmc[AUTONEG_BIT] = dflt.autoneg;
            next_st.bmc[SPEED_BIT]   = dflt.speed;
            next_st.bmc[DUPLEX_BIT]  = dflt.duplex;
            if (st.sr_cnt == 8'h01) begin
                next_st.bmc[RESET_BIT] = 1'b0;
            end
        end else if (wr_hit && !SOFT_STRAP_MODE) begin
            next_st.bmc = REG_WDATA & WRITE_MASK;
            // clearing restart by write leaves a pending one alone unless autoneg is written zero
            next_st.bmc[RESTART_BIT] = st.bmc[RESTART_BIT] | REG_WDATA[RESTART_BIT];
            if (!REG_WDATA[AUTONEG_BIT]) begin
                next_st.bmc[RESTART_BIT] = 1'b0;
            end
            if (REG_WDATA[RESET_BIT]) begin
                next_st.sr_cnt = 8'(SOFT_RESET_CYC);
                next_st.bmc[RESET_BIT] = 1'b1;
            end
        end
        // restart self-clears once negotiation has begun; a new request wins
        if (st.bmc[RESTART_BIT] && AN_STARTED && st.sr_cnt == 8'h00
            && !(wr_hit && !SOFT_STRAP_MODE && REG_WDATA[RESTART_BIT]
                 && REG_WDATA[AUTONEG_BIT])) begin
            next_st.bmc[RESTART_BIT] = 1'b0;
        end
        // low pin forces the power-down bit
        if (!st.pd_sync[1]) begin
            next_st.bmc[PDOWN_BIT] = 1'b1;
        end
        next_st.sreset = (st.sr_cnt != 8'h00);
        // decoded controls
        next_st.ctrl.loopback   = st.bmc[LOOPBACK_BIT];
        next_st.ctrl.powerdown  = st.bmc[PDOWN_BIT] | ~st.pd_sync[1];
        next_st.ctrl.isolate    = st.bmc[ISOLATE_BIT];
        next_st.ctrl.autoneg_en = st.bmc[AUTONEG_BIT];
        next_st.ctrl.restart_an = st.bmc[RESTART_BIT] & st.bmc[AUTONEG_BIT];
        // forced speed and duplex only when negotiation is off
        next_st.ctrl.speed_100   = st.bmc[AUTONEG_BIT] ? 1'b1 : st.bmc[SPEED_BIT];
        next_st.ctrl.full_duplex = st.bmc[AUTONEG_BIT] ? 1'b1 : st.bmc[DUPLEX_BIT];
        next_st.ctrl.col_test   = st.bmc[COLTEST_BIT];
        // read data, management stays live even when isolated or powered down
        next_st.rdata = (REG_RD && REG_ADDR == BASIC_MODE_CONTROL_ADDR)
                        ? (st.bmc & WRITE_MASK) : 16'h0000;
    end

    // state registers; straps loaded once the pin synchroniser has filled
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.pd_sync <= 2'b11;
            st.strap_wait <= 2'h1;
            st.bmc <= {2'b00, STRAP_RESET[1], STRAP_RESET[2], 3'b000,
                       STRAP_RESET[0], 8'h00};
        end else begin
            st <= next_st;
        end
    end

    // collision test timing
    col_test_gen u_col (
        .clk    (REF_CLK),
        .rst    (RST),
        .enable (st.ctrl.col_test),
        .tx_en  (st.tx_sync),
        .col    (col_int)
    );

    assign REG_RDATA      = st.rdata;
    assign CTRL           = st.ctrl;
    assign PHY_SOFT_RESET = st.sreset;
    assign COL            = col_int;
endmodule

/* src/bmc_pkg.sv */
// package: constants and carriers for the basic mode control register block
package bmc_pkg;
    localparam logic [4:0]  BASIC_MODE_CONTROL_ADDR = 5'h00;
    localparam int          RESET_BIT    = 15;
    localparam int          LOOPBACK_BIT = 14;
    localparam int          SPEED_BIT    = 13;
    localparam int          AUTONEG_BIT  = 12;
    localparam int          PDOWN_BIT    = 11;
    localparam int          ISOLATE_BIT  = 10;
    localparam int          RESTART_BIT  = 9;
    localparam int          DUPLEX_BIT   = 8;
    localparam int          COLTEST_BIT  = 7;
    localparam logic [15:0] WRITE_MASK   = 16'hFF80;
    localparam logic [2:0]  STRAP_RESET  = 3'h7;
    // soft reset hold time and collision test delays at the 50 MHz reference
    localparam int          CLK_NS         = 20;
    localparam int          SOFT_RESET_NS  = 1000;
    localparam int          SOFT_RESET_CYC = (SOFT_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int          COL_ON_CYC     = 8;
    localparam int          COL_OFF_CYC    = 1;

    typedef struct packed {
        logic autoneg;
        logic speed;
        logic duplex;
    } strap_s;

    typedef struct packed {
        logic loopback;
        logic powerdown;
        logic isolate;
        logic autoneg_en;
        logic restart_an;
        logic speed_100;
        logic full_duplex;
        logic col_test;
    } phy_ctrl_s;
endpackage

/* src/col_test_gen.sv */
// collision test generator: COL follows TX_EN while enabled
`timescale 1ns/10ps
module col_test_gen
    import bmc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic enable,
    input  wire logic tx_en,
    // result
    output logic      col
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       col;
    } cstate_s;

    cstate_s st;
    cstate_s next_st;

    // delay COL rise by a few cycles, drop it at once
    always_comb begin
        next_st = st;
        if (!enable || !tx_en) begin
            next_st.cnt = '0;
            next_st.col = 1'b0;
        end else if (st.cnt >= 4'(COL_ON_CYC - 1)) begin
            next_st.col = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign col = st.col;
endmodule

/* test/an_engine_model.sv */
// negotiation engine stand-in that acknowledges a restart request
`timescale 1ns/10ps
module an_engine_model #(
    parameter int DLY = 6
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // restart request and acknowledge
    input  wire logic req,
    output logic      started
);
    logic [3:0] cnt;
    // count while a restart waits, then pulse once when negotiation begins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt     <= 4'h0;
            started <= 1'b0;
        end else begin
            started <= req && !started && cnt == 4'(DLY);
            cnt     <= (req && !started) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

/* test/basic_mode_control_tb.sv */
// self-checking bench for the basic mode control register
`timescale 1ns/10ps
module basic_mode_control_tb
    import bmc_pkg::*;
();
    logic        clk, rst, wr, rd, pin_n, tx_en, an_go, sreset, col, smode, cfg;
    logic [2:0]  strap;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, w;
    logic [31:0] seed;
    phy_ctrl_s   ctrl;
    int          fails, compares;
    // design and negotiation engine model
    basic_mode_control dut (.REF_CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .PIN_STRAP(strap), .SOFT_STRAP_MODE(smode),
        .CONFIG_DONE(cfg), .INTERRUPT_POWERDOWN_PIN_N(pin_n), .AN_STARTED(an_go),
        .TX_EN(tx_en), .CTRL(ctrl), .PHY_SOFT_RESET(sreset), .COL(col));
    an_engine_model partner (.clk(clk), .rst(rst), .req(ctrl.restart_an), .started(an_go));
    // expectation helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic phy_ctrl_s ctrl_of(input logic [15:0] v);
        return {v[14], v[11], v[10], v[12], 1'b0, v[12] | v[13], v[12] | v[8], v[7]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register access one cycle per strobe
    task automatic wrt(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) #1;
        wr = 1;
        addr = a;
        wdata = d;
        @(posedge clk) #1;
        wr = 0;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk) #1;
        rd = 1;
        addr = a;
        @(posedge clk) #1;
        rd = 0;
        chk(rdata & m, e);
    endtask
    task automatic results();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // clock
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // watchdog
    initial begin
        #100000;
        fails++;
        results();
    end
    // main sequence
    initial begin
        {rst, wr, rd, addr, wdata, pin_n, tx_en} = {1'b1, 23'h0, 1'b1, 1'b0};
        {smode, cfg, strap} = {2'h0, 3'h5};
        seed = 32'h0000_05DC;
        repeat (5) @(posedge clk);
        #1 rst = 0;
        repeat (4) @(posedge clk);
        rdc(5'h00, 16'h1100, 16'hFFFF);
        repeat (20) begin
            w = 16'(rnd()) & 16'h7DFF;
            wrt(5'h00, w);
            wrt(5'h11, ~w);
            rdc(5'h11, 16'h0000, 16'hFFFF);
            rdc(5'h00, w & 16'h7D80, 16'hFFFF);
            chk({8'h00, ctrl}, {8'h00, ctrl_of(w)});
        end
        wrt(5'h00, 16'h1200);
        rdc(5'h00, 16'h1200, 16'hFFFF);
        wrt(5'h00, 16'h1000);
        rdc(5'h00, 16'h1200, 16'hFFFF);
        repeat (12) @(posedge clk);
        rdc(5'h00, 16'h1000, 16'hFFFF);
        wrt(5'h00, 16'h0000);
        wrt(5'h00, 16'h0200);
        rdc(5'h00, 16'h0000, 16'hFFFF);
        wrt(5'h00, 16'h0080);
        @(posedge clk) #1;
        tx_en = 1;
        repeat (20) @(posedge clk);
        #1 chk({15'h0000, col}, 16'h0001);
        tx_en = 0;
        repeat (5) @(posedge clk);
        #1 chk({15'h0000, col}, 16'h0000);
        pin_n = 0;
        repeat (6) @(posedge clk);
        rdc(5'h00, 16'h0800, 16'h0800);
        pin_n = 1;
        repeat (4) @(posedge clk);
        wrt(5'h00, 16'h0000);
        rdc(5'h00, 16'h0000, 16'hFFFF);
        wrt(5'h00, 16'h4400);
        wrt(5'h00, 16'h8000);
        rdc(5'h00, 16'h8000, 16'h8000);
        chk({15'h0000, sreset}, 16'h0001);
        repeat (60) @(posedge clk);
        rdc(5'h00, 16'h1100, 16'hFFFF);
        chk({15'h0000, sreset}, 16'h0000);
        // second hardware reset with other pin straps
        strap = 3'h2;
        rst = 1;
        repeat (5) @(posedge clk);
        #1 rst = 0;
        repeat (4) @(posedge clk);
        rdc(5'h00, 16'h2000, 16'hFFFF);
        // software straps: stored in strap mode, applied at config done
        smode = 1;
        wrt(5'h00, 16'h1100);
        rdc(5'h00, 16'h2000, 16'hFFFF);
        @(posedge clk) #1;
        cfg = 1;
        @(posedge clk) #1;
        cfg = 0;
        smode = 0;
        rdc(5'h00, 16'h1100, 16'hFFFF);
        wrt(5'h00, 16'h8000);
        repeat (60) @(posedge clk);
        rdc(5'h00, 16'h1100, 16'hFFFF);
        results();
    end
endmodule

/* test/bmc_props.sv */
// assertion checker on the basic mode control register ports
`timescale 1ns/10ps
module bmc_props
    import bmc_pkg::*;
(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST,
    // register access and pins
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [4:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic        SOFT_STRAP_MODE,
    input wire logic        INTERRUPT_POWERDOWN_PIN_N,
    input wire logic        TX_EN,
    // outputs
    input wire phy_ctrl_s   CTRL,
    input wire logic        PHY_SOFT_RESET,
    input wire logic        COL
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // a write that the register takes in functional mode
    logic wr0;
    assign wr0 = REG_WR && REG_ADDR == 5'h00 && !SOFT_STRAP_MODE;
    // properties and their assertions
    property p_rsvd; $past(REG_RD) |-> REG_RDATA[6:0] == 7'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_sr_go; wr0 && REG_WDATA[15] && !PHY_SOFT_RESET |-> ##[1:3] PHY_SOFT_RESET; endproperty
    a_sr_go: assert property (p_sr_go) else $error("soft reset did not start");
    property p_sr_end;
        $fell(PHY_SOFT_RESET) |-> ##[0:2] (!CTRL.loopback && !CTRL.isolate && !CTRL.col_test);
    endproperty
    a_sr_end: assert property (p_sr_end) else $error("soft reset left fields set");
    property p_col_on; $rose(TX_EN) && CTRL.col_test |-> ##[1:20] COL; endproperty
    a_col_on: assert property (p_col_on) else $error("collision not raised");
    property p_col_off; $fell(TX_EN) |-> ##[1:4] !COL; endproperty
    a_col_off: assert property (p_col_off) else $error("collision not dropped");
    property p_ign;
        wr0 && !$past(wr0) && !REG_WDATA[12] && !CTRL.autoneg_en && !CTRL.restart_an
            && !PHY_SOFT_RESET |-> ##1 !CTRL.restart_an ##1 !CTRL.restart_an;
    endproperty
    a_ign: assert property (p_ign) else $error("restart taken while disabled");
    property p_mask; CTRL.autoneg_en |-> CTRL.speed_100 && CTRL.full_duplex; endproperty
    a_mask: assert property (p_mask) else $error("forced mode leaked");
    property p_pd; !INTERRUPT_POWERDOWN_PIN_N [*5] |-> CTRL.powerdown; endproperty
    a_pd: assert property (p_pd) else $error("pin did not power down");
    // main scenarios reached
    cover property ($fell(PHY_SOFT_RESET));
    cover property ($rose(COL));
    cover property ($fell(CTRL.restart_an));
endmodule
bind basic_mode_control bmc_props u_props (.*);
